// file: verilog/bme_map.svh
/*
 * register offsets, field positions, reset values, operation codes and
 * cycle counts of the branch and multiply execution block.
 * assumes inclusion by bare name; holds definitions only.
 */
`ifndef BME_MAP_SVH
`define BME_MAP_SVH
// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define BME_A_CTRL 8'h00
`define BME_A_OPND 8'h04
`define BME_A_PC   8'h08
`define BME_A_ZPTR 8'h0C
`define BME_A_OFS  8'h10
`define BME_A_FLAG 8'h14
`define BME_A_RES  8'h18
`define BME_A_STAT 8'h1C
`define BME_A_STK  8'h20
// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define BME_CTRL_GO  8
`define BME_OPND_RD  0
`define BME_OPND_RR  8
`define BME_OPND_BIT 16
`define BME_OPND_TWO 19
`define BME_F_C 0
`define BME_F_Z 1
`define BME_F_N 2
`define BME_F_V 3
`define BME_F_S 4
`define BME_F_H 5
`define BME_F_T 6
`define BME_F_I 7
// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define BME_PC_RST   16'h0000
`define BME_FLAG_RST 8'h00
`define BME_OP_RST   6'h00
// ----------------------------------------------------------------------
// operation codes
// ----------------------------------------------------------------------
`define BME_OP_MULT_U    6'h00
`define BME_OP_MULT_S    6'h01
`define BME_OP_MULT_SU   6'h02
`define BME_OP_FMULT_U   6'h03
`define BME_OP_FMULT_S   6'h04
`define BME_OP_FMULT_SU  6'h05
`define BME_OP_REL_JUMP  6'h08
`define BME_OP_REL_CALL  6'h09
`define BME_OP_PTR_JUMP  6'h0A
`define BME_OP_PTR_CALL  6'h0B
`define BME_OP_RET_SUB   6'h0C
`define BME_OP_RET_INT   6'h0D
`define BME_OP_CMP_SKIP  6'h10
`define BME_OP_CMP_REG   6'h11
`define BME_OP_CMP_CARRY 6'h12
`define BME_OP_CMP_IMM   6'h13
`define BME_OP_SKIP_RBC  6'h14
`define BME_OP_SKIP_RBS  6'h15
`define BME_OP_SKIP_IBC  6'h16
`define BME_OP_SKIP_IBS  6'h17
`define BME_OP_BR_FSET   6'h18
`define BME_OP_BR_FCLR   6'h19
`define BME_OP_BR_EQ     6'h20
`define BME_OP_BR_NE     6'h21
`define BME_OP_BR_CS     6'h22
`define BME_OP_BR_CC     6'h23
`define BME_OP_BR_SH     6'h24
`define BME_OP_BR_LO     6'h25
`define BME_OP_BR_MI     6'h26
`define BME_OP_BR_PL     6'h27
`define BME_OP_BR_GE     6'h28
`define BME_OP_BR_LT     6'h29
`define BME_OP_BR_HS     6'h2A
`define BME_OP_BR_HC     6'h2B
`define BME_OP_BR_TS     6'h2C
`define BME_OP_BR_TC     6'h2D
// ----------------------------------------------------------------------
// cycle counts
// ----------------------------------------------------------------------
`define BME_CYC_MULT  3'h2
`define BME_CYC_RELATIVE_JUMP  3'h2
`define BME_CYC_RELATIVE_CALL 3'h3
`define BME_CYC_POINTER_JUMP  3'h2
`define BME_CYC_POINTER_CALL 3'h3
`define BME_CYC_RET   3'h4
`define BME_CYC_ONE   3'h1
`define BME_CYC_BR_T  3'h2
`define BME_CYC_SK1   3'h2
`define BME_CYC_SK2   3'h3
`endif

// file: verilog/bme_pkg.sv
/*
 * types of the branch and multiply execution block.
 * assumes bme_map.svh is on the include path.
 */
`include "bme_map.svh"
package bme_pkg;
  // --------------------------------------------------------------------
  // engine state and register image
  // --------------------------------------------------------------------
  typedef enum logic [0:0] {ST_IDLE, ST_EXEC} bme_state_t;
  typedef struct packed {
    bme_state_t       st;
    logic             ack;
    logic [31:0]      dat;
    logic [5:0]       op;
    logic [19:0]      opnd;
    logic [15:0]      pc;
    logic [15:0]      z;
    logic [15:0]      ofs;
    logic [15:0]      res;
    logic [7:0]       flag;
    logic [7:0][15:0] stk;
    logic [2:0]       sp;
    logic [2:0]       cnt;
    logic [2:0]       last;
    logic             taken;
    logic             bad;
  } bme_core_t;
endpackage

// file: verilog/bme_mul.sv
/*
 * 8 by 8 multiplier with signed, mixed and fractional forms.
 * assumes a purely combinational use inside the core.
 */
module bme_mul (
  input  wire logic [7:0]  rd_i,
  input  wire logic [7:0]  rr_i,
  input  wire logic        sgn_d_i,
  input  wire logic        sgn_r_i,
  input  wire logic        frac_i,
  output logic      [15:0] prod_o,
  output logic             zero_o,
  output logic             carry_o
);
  logic signed [8:0]  a;
  logic signed [8:0]  b;
  logic signed [17:0] p;
  logic        [15:0] raw;
  always_comb begin
    a = {sgn_d_i & rd_i[7], rd_i};
    b = {sgn_r_i & rr_i[7], rr_i};
    p = a * b;
    raw = p[15:0];
    // carry is taken before the fractional shift drops it
    prod_o = frac_i ? {raw[14:0], 1'b0} : raw;
    carry_o = raw[15];
    zero_o = (prod_o == 16'h0000);
  end
endmodule

// file: verilog/bme_cmp.sv
/*
 * 8 bit compare: subtraction whose result is only used for flags.
 * assumes a purely combinational use inside the core.
 */
module bme_cmp (
  input  wire logic [7:0] a_i,
  input  wire logic [7:0] b_i,
  input  wire logic       cin_i,
  output logic            c_o,
  output logic            z_o,
  output logic            n_o,
  output logic            v_o,
  output logic            h_o
);
  logic [8:0] d;
  logic [7:0] r;
  always_comb begin
    d = {1'b0, a_i} - {1'b0, b_i} - {8'h00, cin_i};
    r = d[7:0];
    c_o = d[8];
    z_o = (r == 8'h00);
    n_o = r[7];
    v_o = (a_i[7] & ~b_i[7] & ~r[7]) | (~a_i[7] & b_i[7] & r[7]);
    h_o = (~a_i[3] & b_i[3]) | (b_i[3] & r[3]) | (r[3] & ~a_i[3]);
  end
endmodule

// file: verilog/bme_core.sv
/*
 * branch and multiply execution core behind a classic wishbone slave.
 * software loads operands, program counter, pointer, offset and status,
 * then starts one operation; the core stays busy for its cycle count.
 * assumes one 50 MHz clock and a synchronous active high reset.
 */
// The address map and the Wishbone register port were chosen for this implementation.
`include "bme_map.svh"
// Operation
// - integer multiplies write 16-bit product to pair, flags Z C, two cycles
// - fractional multiplies shift product left one, flags Z C, two cycles
// - relative jump goes to pc plus offset plus one; call same, three cycles
// - pointer jump loads pc from Z pointer, no flags, two cycles
// - pointer call loads pc from Z pointer, no flags, three cycles
// - compare skip equal advances two or three when equal, one to three cycles
// - compares subtract without storing, set Z N V C H in one cycle
// - register bit skips advance two or three on matching bit
// - io bit skips advance two or three on matching io bit
// - status bit branches go to pc plus offset plus one, one or two cycles
// - equal and not equal branches follow the zero flag
// - carry set and lower on carry one, clear and same-or-higher on zero
// - minus and plus branches follow the negative flag
// - signed ge and lt branches follow negative xor overflow
// - half carry branches follow half carry, one or two cycles
// - transfer bit branches follow the transfer flag
module bme_core
  import bme_pkg::*;
(
  input  wire logic        CLK_I,
  input  wire logic        SRST_I,
  input  wire logic        CYC_I,
  input  wire logic        STB_I,
  input  wire logic        WE_I,
  input  wire logic [7:0]  ADR_I,
  input  wire logic [3:0]  SEL_I,
  input  wire logic [31:0] DAT_I,
  output logic      [31:0] DAT_O,
  output logic             ACK_O,
  output logic             BUSY_O
);
  // --------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  sel);
    logic [31:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    return (old_v & ~m) | (new_v & m);
  endfunction

  // branch table: {known, wanted level, use n xor v, flag index}
  function automatic logic [5:0] br_sel(input logic [5:0] op,
                                        input logic [2:0] s);
    logic [5:0] t;
    t = 6'h00;
    unique case (op)
      `BME_OP_BR_FSET: t = {3'h6, s};
      `BME_OP_BR_FCLR: t = {3'h4, s};
      `BME_OP_BR_EQ:   t = {3'h6, 3'(`BME_F_Z)};
      `BME_OP_BR_NE:   t = {3'h4, 3'(`BME_F_Z)};
      `BME_OP_BR_CS:   t = {3'h6, 3'(`BME_F_C)};
      `BME_OP_BR_LO:   t = {3'h6, 3'(`BME_F_C)};
      `BME_OP_BR_CC:   t = {3'h4, 3'(`BME_F_C)};
      `BME_OP_BR_SH:   t = {3'h4, 3'(`BME_F_C)};
      `BME_OP_BR_MI:   t = {3'h6, 3'(`BME_F_N)};
      `BME_OP_BR_PL:   t = {3'h4, 3'(`BME_F_N)};
      `BME_OP_BR_GE:   t = {3'h5, 3'h0};
      `BME_OP_BR_LT:   t = {3'h7, 3'h0};
      `BME_OP_BR_HS:   t = {3'h6, 3'(`BME_F_H)};
      `BME_OP_BR_HC:   t = {3'h4, 3'(`BME_F_H)};
      `BME_OP_BR_TS:   t = {3'h6, 3'(`BME_F_T)};
      `BME_OP_BR_TC:   t = {3'h4, 3'(`BME_F_T)};
      default:         t = 6'h00;
    endcase
    return t;
  endfunction

  // --------------------------------------------------------------------
  // state and arithmetic units
  // --------------------------------------------------------------------
  bme_core_t   q_r;
  bme_core_t   q_nxt;
  logic [7:0]  rd_v;
  logic [7:0]  rr_v;
  logic        two_w;
  logic [2:0]  bsel;
  logic        m_sd;
  logic        m_sr;
  logic        m_fr;
  logic [15:0] m_prod;
  logic        m_z;
  logic        m_c;
  logic        c_c;
  logic        c_z;
  logic        c_n;
  logic        c_v;
  logic        c_h;
  logic        cin;

  assign rd_v  = q_r.opnd[`BME_OPND_RD +: 8];
  assign rr_v  = q_r.opnd[`BME_OPND_RR +: 8];
  assign bsel  = q_r.opnd[`BME_OPND_BIT +: 3];
  assign two_w = q_r.opnd[`BME_OPND_TWO];
  assign m_sd  = (q_r.op != `BME_OP_MULT_U) && (q_r.op != `BME_OP_FMULT_U);
  assign m_sr  = (q_r.op == `BME_OP_MULT_S) || (q_r.op == `BME_OP_FMULT_S);
  assign m_fr  = (q_r.op >= `BME_OP_FMULT_U) && (q_r.op <= `BME_OP_FMULT_SU);
  assign cin   = (q_r.op == `BME_OP_CMP_CARRY) & q_r.flag[`BME_F_C];

  bme_mul u_mul (
    .rd_i    (rd_v),
    .rr_i    (rr_v),
    .sgn_d_i (m_sd),
    .sgn_r_i (m_sr),
    .frac_i  (m_fr),
    .prod_o  (m_prod),
    .zero_o  (m_z),
    .carry_o (m_c)
  );

  bme_cmp u_cmp (
    .a_i   (rd_v),
    .b_i   (rr_v),
    .cin_i (cin),
    .c_o   (c_c),
    .z_o   (c_z),
    .n_o   (c_n),
    .v_o   (c_v),
    .h_o   (c_h)
  );

  // --------------------------------------------------------------------
  // decode of the loaded operation
  // --------------------------------------------------------------------
  logic [15:0] npc;
  logic [15:0] seq_pc;
  logic [15:0] tgt_pc;
  logic [15:0] skp_pc;
  logic [2:0]  skp_cyc;
  logic [7:0]  nsreg;
  logic [2:0]  ncyc;
  logic [5:0]  bt;
  logic        bflag;
  logic        hit;
  logic        wres;
  logic        push;
  logic        pop;
  logic        nbad;

  always_comb begin
    seq_pc  = q_r.pc + 16'h0001;
    tgt_pc  = q_r.pc + q_r.ofs + 16'h0001;
    skp_pc  = q_r.pc + (two_w ? 16'h0003 : 16'h0002);
    skp_cyc = two_w ? `BME_CYC_SK2 : `BME_CYC_SK1;
    bt      = br_sel(q_r.op, bsel);
    bflag   = bt[3] ? (q_r.flag[`BME_F_N] ^ q_r.flag[`BME_F_V])
                    : q_r.flag[bt[2:0]];
    npc   = seq_pc;
    nsreg = q_r.flag;
    ncyc  = `BME_CYC_ONE;
    hit   = 1'b0;
    wres  = 1'b0;
    push  = 1'b0;
    pop   = 1'b0;
    nbad  = 1'b0;
    unique case (q_r.op)
      `BME_OP_MULT_U, `BME_OP_MULT_S, `BME_OP_MULT_SU,
      `BME_OP_FMULT_U, `BME_OP_FMULT_S, `BME_OP_FMULT_SU: begin
        wres = 1'b1;
        nsreg[`BME_F_Z] = m_z;
        nsreg[`BME_F_C] = m_c;
        ncyc = `BME_CYC_MULT;
      end
      `BME_OP_REL_JUMP: begin
        npc  = tgt_pc;
        ncyc = `BME_CYC_RELATIVE_JUMP;
      end
      `BME_OP_REL_CALL: begin
        npc  = tgt_pc;
        push = 1'b1;
        ncyc = `BME_CYC_RELATIVE_CALL;
      end
      `BME_OP_PTR_JUMP: begin
        npc  = q_r.z;
        ncyc = `BME_CYC_POINTER_JUMP;
      end
      `BME_OP_PTR_CALL: begin
        npc  = q_r.z;
        push = 1'b1;
        ncyc = `BME_CYC_POINTER_CALL;
      end
      `BME_OP_RET_SUB, `BME_OP_RET_INT: begin
        npc  = q_r.stk[q_r.sp - 3'h1];
        pop  = 1'b1;
        ncyc = `BME_CYC_RET;
        if (q_r.op == `BME_OP_RET_INT) begin
          nsreg[`BME_F_I] = 1'b1;
        end
      end
      `BME_OP_CMP_SKIP: begin
        hit = (rd_v == rr_v);
      end
      `BME_OP_CMP_REG, `BME_OP_CMP_CARRY, `BME_OP_CMP_IMM: begin
        nsreg[`BME_F_C] = c_c;
        nsreg[`BME_F_N] = c_n;
        nsreg[`BME_F_V] = c_v;
        nsreg[`BME_F_S] = c_n ^ c_v;
        nsreg[`BME_F_H] = c_h;
        // carry form only keeps zero when the whole chain is zero
        nsreg[`BME_F_Z] = (q_r.op == `BME_OP_CMP_CARRY) ?
                          (c_z & q_r.flag[`BME_F_Z]) : c_z;
      end
      `BME_OP_SKIP_RBC: hit = ~rd_v[bsel];
      `BME_OP_SKIP_RBS: hit = rd_v[bsel];
      `BME_OP_SKIP_IBC: hit = ~rr_v[bsel];
      `BME_OP_SKIP_IBS: hit = rr_v[bsel];
      default: begin
        if (bt[5]) begin
          hit = (bflag == bt[4]);
          if (hit) begin
            npc  = tgt_pc;
            ncyc = `BME_CYC_BR_T;
          end
        end else begin
          // unknown code: pc and flags held, bad status bit set, taken cleared, last length one
          nbad = 1'b1;
          npc  = q_r.pc;
        end
      end
    endcase
    if (hit && (q_r.op >= `BME_OP_CMP_SKIP) &&
        (q_r.op <= `BME_OP_SKIP_IBS)) begin
      npc  = skp_pc;
      ncyc = skp_cyc;
    end
  end

  // --------------------------------------------------------------------
  // bus slave and engine
  // --------------------------------------------------------------------
  logic        req;
  logic        wr;
  logic        idle;
  logic [31:0] rdat;

  always_comb begin
    q_nxt = q_r;
    req   = CYC_I & STB_I;
    wr    = req & WE_I & q_r.ack;
    idle  = (q_r.st == ST_IDLE);
    q_nxt.ack = req & ~q_r.ack;
    unique case (ADR_I)
      `BME_A_CTRL: rdat = {26'h0, q_r.op};
      `BME_A_OPND: rdat = {12'h0, q_r.opnd};
      `BME_A_PC:   rdat = {16'h0, q_r.pc};
      `BME_A_ZPTR: rdat = {16'h0, q_r.z};
      `BME_A_OFS:  rdat = {16'h0, q_r.ofs};
      `BME_A_FLAG: rdat = {24'h0, q_r.flag};
      `BME_A_RES:  rdat = {16'h0, q_r.res};
      `BME_A_STAT: rdat = {21'h0, q_r.sp, 1'b0, q_r.last,
                           1'b0, q_r.bad, q_r.taken, ~idle};
      `BME_A_STK:  rdat = {16'h0, q_r.stk[q_r.sp - 3'h1]};
      default:     rdat = 32'h0000_0000;
    endcase
    if (q_nxt.ack) begin
      q_nxt.dat = rdat;
    end
    // loaded values are frozen while an operation runs
    if (wr && idle) begin
      unique case (ADR_I)
        `BME_A_CTRL: begin
          q_nxt.op = 6'(merge({26'h0, q_r.op}, DAT_I, SEL_I));
          if (SEL_I[1] && DAT_I[`BME_CTRL_GO]) begin
            q_nxt.st  = ST_EXEC;
            q_nxt.cnt = 3'h1;
          end
        end
        `BME_A_OPND: q_nxt.opnd = 20'(merge({12'h0, q_r.opnd}, DAT_I, SEL_I));
        `BME_A_PC:   q_nxt.pc   = 16'(merge({16'h0, q_r.pc}, DAT_I, SEL_I));
        `BME_A_ZPTR: q_nxt.z    = 16'(merge({16'h0, q_r.z}, DAT_I, SEL_I));
        `BME_A_OFS:  q_nxt.ofs  = 16'(merge({16'h0, q_r.ofs}, DAT_I, SEL_I));
        `BME_A_FLAG: q_nxt.flag = 8'(merge({24'h0, q_r.flag}, DAT_I, SEL_I));
        default: ;
      endcase
    end
    unique case (q_r.st)
      ST_IDLE: ;
      ST_EXEC: begin
        q_nxt.cnt = q_r.cnt + 3'h1;
        if (q_r.cnt == ncyc) begin
          // everything lands on the last cycle of the operation
          q_nxt.st    = ST_IDLE;
          q_nxt.pc    = npc;
          q_nxt.flag  = nsreg;
          q_nxt.last  = ncyc;
          q_nxt.taken = hit;
          q_nxt.bad   = nbad;
          if (wres) begin
            q_nxt.res = m_prod;
          end
          if (push) begin
            q_nxt.stk[q_r.sp] = seq_pc;
            q_nxt.sp = q_r.sp + 3'h1;
          end
          if (pop) begin
            q_nxt.sp = q_r.sp - 3'h1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      q_r      <= '0;
      q_r.st   <= ST_IDLE;
      q_r.op   <= `BME_OP_RST;
      q_r.pc   <= `BME_PC_RST;
      q_r.flag <= `BME_FLAG_RST;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign DAT_O  = q_r.dat;
  assign ACK_O  = q_r.ack;
  assign BUSY_O = (q_r.st == ST_EXEC);
endmodule

// file: verif/bme_core_assertions.sv
/*
 * port checker of bme_core: bus answer timing and operation lengths.
 * assumes it is bound to bme_core and sees only that module's ports.
 */
`include "bme_map.svh"
module bme_core_assertions (
  input wire logic        CLK_I,
  input wire logic        SRST_I,
  input wire logic        CYC_I,
  input wire logic        STB_I,
  input wire logic        WE_I,
  input wire logic [7:0]  ADR_I,
  input wire logic [3:0]  SEL_I,
  input wire logic [31:0] DAT_I,
  input wire logic [31:0] DAT_O,
  input wire logic        ACK_O,
  input wire logic        BUSY_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SRST_I);
  // --------------------------------------------------------------------
  // helper state
  // --------------------------------------------------------------------
  logic       go;
  logic       go_r;
  logic [5:0] op_r;
  logic [2:0] cnt_r;
  // a start while busy is refused, so it must not retag the running op
  assign go = CYC_I && STB_I && ACK_O && WE_I && ADR_I == `BME_A_CTRL
              && SEL_I[1] && DAT_I[`BME_CTRL_GO] && !BUSY_O;
  always_ff @(posedge CLK_I) begin
    go_r  <= !SRST_I && go;
    op_r  <= SRST_I ? 6'h00 : (go ? DAT_I[5:0] : op_r);
    cnt_r <= (SRST_I || !BUSY_O) ? 3'h0 : cnt_r + 3'h1;
  end
  // --------------------------------------------------------------------
  // properties
  // --------------------------------------------------------------------
  sequence s_req;
    CYC_I && STB_I && !ACK_O;
  endsequence
  sequence s_pulse;
    ACK_O ##1 !ACK_O;
  endsequence
  property p_ack; s_req |=> ACK_O; endproperty
  property p_ack_once; ACK_O |-> s_pulse; endproperty
  property p_dat_hold; $changed(DAT_O) |-> $rose(ACK_O); endproperty
  property p_unmapped;
    ACK_O && !WE_I && ADR_I > `BME_A_STK |-> DAT_O == 32'h00000000;
  endproperty
  property p_start; $rose(BUSY_O) |-> go_r || $past(go_r); endproperty
  property p_len(logic [5:0] lo, logic [5:0] hi, logic [2:0] n);
    $fell(BUSY_O) && op_r >= lo && op_r <= hi |-> cnt_r == n;
  endproperty
  property p_skip_len;
    $fell(BUSY_O) && op_r inside {6'h10, [6'h14:6'h17]}
      |-> cnt_r inside {[3'h1:3'h3]};
  endproperty
  property p_br_len;
    $fell(BUSY_O) && op_r inside {[6'h18:6'h19], [6'h20:6'h2D]}
      |-> cnt_r inside {3'h1, 3'h2};
  endproperty
  a_ack: assert property (p_ack) else $error("ack late");
  a_ack_once: assert property (p_ack_once) else $error("ack too long");
  a_dat_hold: assert property (p_dat_hold) else $error("read data moved");
  a_unmapped: assert property (p_unmapped) else $error("unmapped not 0");
  a_start: assert property (p_start) else $error("busy without start");
  a_mult_len: assert property (p_len(6'h00, 6'h05, 3'h2))
    else $error("multiply length");
  a_relative_jump_len: assert property (p_len(6'h08, 6'h08, 3'h2))
    else $error("relative jump length");
  a_relative_call_len: assert property (p_len(6'h09, 6'h09, 3'h3))
    else $error("relative call length");
  a_pjmp_len: assert property (p_len(6'h0A, 6'h0A, 3'h2))
    else $error("pointer jump length");
  a_pcall_len: assert property (p_len(6'h0B, 6'h0B, 3'h3))
    else $error("pointer call length");
  a_cmp_len: assert property (p_len(6'h11, 6'h13, 3'h1))
    else $error("compare length");
  a_skip_len: assert property (p_skip_len)
    else $error("skip length");
  a_br_len: assert property (p_br_len)
    else $error("branch length");
endmodule
bind bme_core bme_core_assertions u_bme_core_assertions (
  .CLK_I(CLK_I), .SRST_I(SRST_I), .CYC_I(CYC_I), .STB_I(STB_I),
  .WE_I(WE_I), .ADR_I(ADR_I), .SEL_I(SEL_I), .DAT_I(DAT_I),
  .DAT_O(DAT_O), .ACK_O(ACK_O), .BUSY_O(BUSY_O));

// file: verif/bme_core_tb.sv
/*
 * self-checking bench of bme_core: every operation code, random operands.
 * assumes the design files and bme_map.svh are compiled before it.
 */
`include "bme_map.svh"
module bme_core_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, srst, cyc, stb, we, ack, busy;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat;
  logic [15:0] g_pc, g_z, g_ofs, g_res, lfsr_r, r1, r2;
  logic [7:0]  g_sr;
  logic [15:0] stk_q[$];
  logic [7:0]  sr_save [64];
  int          miscompares, compares;
  bme_core u_bme_core (.CLK_I(clk), .SRST_I(srst), .CYC_I(cyc),
    .STB_I(stb), .WE_I(we), .ADR_I(adr), .SEL_I(sel), .DAT_I(wdat),
    .DAT_O(rdat), .ACK_O(ack), .BUSY_O(busy));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // --------------------------------------------------------------------
  // shared tasks
  // --------------------------------------------------------------------
  task automatic check(input string nm, input logic [31:0] s, e);
    compares++;
    if (s !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic finish_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // one classic cycle; the wait is bounded, a lost ack is a mismatch
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    check("ack", {31'h0, ack}, 32'h1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rd_chk(input string nm, input logic [7:0] a,
                        input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    check(nm, q, e);
  endtask
  function automatic logic [15:0] rnd();
    lfsr_r = {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12]
              ^ lfsr_r[10]};
    return lfsr_r;
  endfunction
  // --------------------------------------------------------------------
  // expected outcome of one operation
  // --------------------------------------------------------------------
  function automatic void predict(input logic [5:0] op,
    input logic [19:0] od, output logic [15:0] pc,
    output logic [7:0] sr, output logic [15:0] rs, output logic [2:0] cy,
    output logic tk);
    logic [7:0]  a, b, r;
    logic [15:0] p;
    logic [8:0]  d;
    logic        f;
    a = od[7:0];
    b = od[15:8];
    pc = g_pc + 16'h0001;
    sr = g_sr;
    rs = g_res;
    cy = 3'h1;
    f = 1'b0;
    if (op <= 6'h05) begin
      p = {{8{op inside {6'h01, 6'h02, 6'h04, 6'h05} & a[7]}}, a}
          * {{8{op inside {6'h01, 6'h04} & b[7]}}, b};
      sr[0] = p[15];
      if (op >= 6'h03) p = p << 1;
      sr[1] = (p == 16'h0000);
      rs = p;
      cy = 3'h2;
    end else if (op inside {[6'h08:6'h0B]}) begin
      pc = op[1] ? g_z : g_pc + g_ofs + 16'h0001;
      cy = op[0] ? 3'h3 : 3'h2;
    end else if (op inside {6'h0C, 6'h0D}) begin
      pc = stk_q[$];
      sr[7] = sr[7] | op[0];
      cy = 3'h4;
    end else if (op inside {[6'h11:6'h13]}) begin
      d = {1'b0, a} - {1'b0, b} - {8'h00, op == 6'h12 & g_sr[0]};
      r = d[7:0];
      sr[0] = d[8];
      sr[1] = (r == 8'h00) & (op != 6'h12 | g_sr[1]);
      sr[2] = r[7];
      sr[3] = a[7] & ~b[7] & ~r[7] | ~a[7] & b[7] & r[7];
      sr[4] = sr[2] ^ sr[3];
      sr[5] = ~a[3] & b[3] | b[3] & r[3] | r[3] & ~a[3];
    end else if (op inside {6'h10, [6'h14:6'h17]}) begin
      f = (op == 6'h10) ? (a == b) : (b[od[18:16]] ^ ~op[0]);
      if (f) pc = g_pc + (od[19] ? 16'h0003 : 16'h0002);
      if (f) cy = od[19] ? 3'h3 : 3'h2;
    end else if (op inside {6'h18, 6'h19, [6'h20:6'h2D]}) begin
      if (!op[5]) f = g_sr[od[18:16]];
      else case (op[3:1])
        3'h0: f = g_sr[1];
        3'h1: f = g_sr[0];
        3'h2: f = ~g_sr[0];
        3'h3: f = g_sr[2];
        3'h4: f = ~(g_sr[2] ^ g_sr[3]);
        3'h5: f = g_sr[5];
        default: f = g_sr[6];
      endcase
      f = f ^ op[0];
      if (f) pc = g_pc + g_ofs + 16'h0001;
      if (f) cy = 3'h2;
    end else pc = g_pc;
    tk = f;
  endfunction
  task automatic run_op(input logic [5:0] op, input logic [19:0] od);
    logic [15:0] epc, ers;
    logic [7:0]  esr;
    logic        etk;
    logic [2:0]  ecy;
    int          nb;
    wr(`BME_A_PC, {16'h0, g_pc});
    wr(`BME_A_ZPTR, {16'h0, g_z});
    wr(`BME_A_OFS, {16'h0, g_ofs});
    wr(`BME_A_FLAG, {24'h0, g_sr});
    wr(`BME_A_OPND, {12'h0, od});
    predict(op, od, epc, esr, ers, ecy, etk);
    wr(`BME_A_CTRL, {16'h0, 7'h00, 1'b1, 2'b00, op});
    nb = 0;
    // busy rises at the write edge, so the window opens just after it
    repeat (8) begin
      #1;
      if (busy === 1'b1) nb++;
      @(posedge clk);
    end
    if (op inside {6'h09, 6'h0B}) stk_q.push_back(g_pc + 16'h0001);
    if (op inside {6'h0C, 6'h0D}) void'(stk_q.pop_back());
    g_res = ers;
    check("busy cycles", 32'(nb), {29'h0, ecy});
    rd_chk("pc", `BME_A_PC, {16'h0, epc});
    rd_chk("flag", `BME_A_FLAG, {24'h0, esr});
    rd_chk("res", `BME_A_RES, {16'h0, ers});
    rd_chk("stat", `BME_A_STAT, {21'h0, 3'(stk_q.size()), 1'b0, ecy,
      1'b0, op == 6'h3F, etk, 1'b0});
    if (op inside {6'h09, 6'h0B})
      rd_chk("stk", `BME_A_STK, {16'h0, stk_q[$]});
  endtask
  // --------------------------------------------------------------------
  // main sequence and watchdog
  // --------------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    finish_test();
  end
  initial begin
    {srst, cyc, stb, we, adr, sel, wdat} = {1'b1, 47'h0};
    sel = 4'hF;
    lfsr_r = 16'h002E;
    g_res = 16'h0000;
    miscompares = 0;
    compares = 0;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    rd_chk("pc reset", `BME_A_PC, 32'h0);
    rd_chk("stat reset", `BME_A_STAT, 32'h0);
    rd_chk("unmapped", 8'h24, 32'h0);
    wr(`BME_A_RES, 32'h0000FFFF);
    rd_chk("res read only", `BME_A_RES, 32'h0);
    sel <= 4'h1;
    wr(`BME_A_PC, 32'h0000ABCD);
    sel <= 4'hF;
    rd_chk("pc lane write", `BME_A_PC, 32'h000000CD);
    $display("test reset and map done");
    for (int rn = 0; rn < 2; rn++) begin
      for (int o = 0; o < 64; o++) begin
        if (o inside {6, 7, 14, 15, [26:31], [46:62]}) continue;
        g_pc = rnd();
        g_z = rnd();
        g_ofs = rnd();
        r1 = rnd();
        r2 = rnd();
        // second round flips every flag so each fixed-flag branch except ge and lt, which follow n xor v, goes both ways
        if (rn == 0) sr_save[o] = r2[15:8];
        g_sr = rn == 0 ? sr_save[o] : ~sr_save[o];
        if (o inside {[20:23]} || (o == 16 && rn == 0)) r1[15:8] = r1[7:0];
        run_op(6'(o), {r2[3] ^ rn[0], r2[2:0], r1});
      end
      $display("test operations round %0d done", rn);
    end
    g_pc = 16'h7FFF;
    run_op(`BME_OP_REL_CALL, 20'h0);
    wr(`BME_A_CTRL, {16'h0, 7'h00, 1'b1, 2'b00, `BME_OP_RET_SUB});
    wr(`BME_A_PC, 32'h0000FFFF);
    repeat (8) @(posedge clk);
    rd_chk("pc busy write", `BME_A_PC, {16'h0, stk_q.pop_back()});
    $display("test refused write done");
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    rd_chk("pc second reset", `BME_A_PC, 32'h0);
    rd_chk("stat second reset", `BME_A_STAT, 32'h0);
    $display("test second reset done");
    finish_test();
  end
endmodule
